//--- ncs_ctrl.v
// Control and status registers for the nonvolatile configuration store.
// Overview. Software reaches four byte registers through the serial port
// address, write strobe and read strobe. A write of 1 to the trigger bit
// copies the buffer bank into the store. A write of 1 to the reload bit,
// while the boot-select pin is low, reloads settings from the store and
// then pulses soft_reset. Both jobs share one transfer engine, so only
// one of them runs at a time. A request that arrives while the engine is
// busy is dropped, not queued. Software polls the pending flag instead.
//
// The write-enable bit only gates the final commit pulse. A protected
// store write still runs the full transfer time and still updates the
// error flag. This keeps the timing seen by software the same whatever
// the protection state, at the cost of a wasted transfer.
//
// The pending flag already reads 1 in the cycle after the request write,
// before the engine has raised its own busy flag. Without that, a poll
// that follows the trigger write directly could see a stale 0.
//
// The boot-select pin comes from outside the clock domain and passes a
// two-flop synchroniser. A reload request must therefore follow a change
// of the pin by at least two clock edges to see the new level.
//
`include "ncs_defs.vh"
`default_nettype none
module ncs_ctrl #(
  parameter XFER_CYCLES = `NCS_XFER_CYCLES
) (
  input  wire        ref_clk,        // Serial port clock, 10 MHz.
  input  wire        nrst,           // Synchronous reset, active low.
  input  wire [11:0] reg_addr,       // Register address from serial port.
  input  wire [7:0]  reg_wdata,      // Write data.
  input  wire        reg_wr,         // One-cycle write strobe.
  input  wire        reg_rd,         // One-cycle read strobe.
  output reg  [7:0]  reg_rdata,      // Read data, valid after reg_rd.
  input  wire        status_pin_sel, // Status pin select bit.
  input  wire        boot_sel_pin,   // Boot-select pin, asynchronous.
  input  wire        nvm_data_bad,   // Integrity result from the array.
  output reg         status_pin,     // General status output.
  output reg         nvm_write_go,   // Pulse: commit buffer into store.
  output reg         soft_reset      // Pulse: reset from stored settings.
);
  // One-hot request tracker: which kind of transfer owns the engine.
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_RELOAD = 3'b010;
  localparam [2:0] ST_STORE  = 3'b100;

  reg        boot_meta;
  reg        boot_sync;
  reg        wr_enable;
  reg  [2:0] req_state;
  reg  [2:0] next_req_state;
  reg        next_wr_enable;
  reg        next_start;
  reg        next_start_write;
  reg        start;
  reg        start_write;
  wire       store_req;
  wire       reload_req;
  wire       pending;
  wire       wr_control;
  wire       wr_trigger;
  wire       engine_free;
  wire       busy;
  wire       done;
  wire       err;

  // True when a write strobe lands on the given register offset.
  function reg_hit;
    input        strobe;
    input [11:0] addr;
    input [11:0] target;
    begin
      reg_hit = strobe && (addr == target);
    end
  endfunction

  // Places a single status flag in bit 0 of a register byte.
  function [7:0] flag_byte;
    input flag;
    begin
      flag_byte = {7'h00, flag};
    end
  endfunction

  // Two-flop synchroniser on the boot-select pin. It resets high, the
  // level that refuses a reload, so no reload slips in right after reset.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      boot_meta <= 1'b1;
      boot_sync <= 1'b1;
    end else begin
      boot_meta <= boot_sel_pin;
      boot_sync <= boot_meta;
    end
  end

  // Request flags decoded from the tracker state.
  assign store_req   = req_state[2];
  assign reload_req  = req_state[1];
  // Pending covers the start cycle, before the engine shows busy.
  assign pending     = busy | start;
  assign wr_control  = reg_hit(reg_wr, reg_addr, `NCS_ADDR_CONTROL);
  assign wr_trigger  = reg_hit(reg_wr, reg_addr, `NCS_ADDR_TRIGGER);
  // A request one cycle after another would see the engine not yet busy,
  // so the start pulse itself also marks the engine as taken.
  assign engine_free = !busy && !start;

  // Next-state logic. The engine drops busy in the cycle of the done
  // pulse, so a request that lands on that cycle is taken, except a store
  // write at the end of a reload, and wins over the clear of the finished request.
  always @* begin
    next_req_state   = req_state;
    next_wr_enable   = wr_enable;
    next_start       = 1'b0;
    next_start_write = start_write;
    if (wr_control) begin
      next_wr_enable = reg_wdata[`NCS_BIT_WREN];
    end
    if (done) begin
      next_req_state = ST_IDLE;
    end
    case (req_state)
      ST_IDLE, ST_STORE: begin
        if (wr_control && reg_wdata[`NCS_BIT_RELOAD] && !boot_sync &&
            engine_free) begin
          next_req_state   = ST_RELOAD;
          next_start       = 1'b1;
          next_start_write = 1'b0;
        end else if (wr_trigger && reg_wdata[`NCS_BIT_STORE] &&
                     engine_free) begin
          // Protected writes still run the sequence but never commit.
          next_req_state   = ST_STORE;
          next_start       = 1'b1;
          next_start_write = 1'b1;
        end
      end
      ST_RELOAD: begin
        // A reload restarts the device, so a store write that lands on
        // the end of a reload is dropped rather than queued behind it.
        if (wr_control && reg_wdata[`NCS_BIT_RELOAD] && !boot_sync &&
            engine_free) begin
          next_req_state   = ST_RELOAD;
          next_start       = 1'b1;
          next_start_write = 1'b0;
        end
      end
      default: begin
        next_req_state = ST_IDLE;
      end
    endcase
  end

  // Request registers. The enable bit leaves reset cleared, so the store
  // stays protected until software arms it on purpose.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      req_state   <= ST_IDLE;
      wr_enable   <= `NCS_WREN_RST;
      start       <= 1'b0;
      start_write <= 1'b0;
    end else begin
      req_state   <= next_req_state;
      wr_enable   <= next_wr_enable;
      start       <= next_start;
      start_write <= next_start_write;
    end
  end

  ncs_xfer #(
    .XFER_CYCLES (XFER_CYCLES)
  ) u_xfer (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .start    (start),
    .is_write (start_write),
    .data_bad (nvm_data_bad),
    .busy     (busy),
    .done     (done),
    .err      (err)
  );

  // Read mux and output pulses, all registered.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      reg_rdata    <= 8'h00;
      status_pin   <= 1'b0;
      nvm_write_go <= 1'b0;
      soft_reset   <= 1'b0;
    end else begin
      status_pin   <= status_pin_sel & pending;
      nvm_write_go <= done & store_req & wr_enable;
      soft_reset   <= done & reload_req;
      if (reg_rd) begin
        case (reg_addr)
          `NCS_ADDR_STATUS:  reg_rdata <= flag_byte(pending);
          `NCS_ADDR_ERROR:   reg_rdata <= flag_byte(err);
          `NCS_ADDR_CONTROL: reg_rdata <= {6'h00, reload_req, wr_enable};
          `NCS_ADDR_TRIGGER: reg_rdata <= flag_byte(store_req);
          default:           reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- ncs_defs.vh
// Register offsets, field positions and timing counts for the config store.
`ifndef NCS_DEFS_VH
`define NCS_DEFS_VH
`define NCS_ADDR_STATUS  12'hb00
`define NCS_ADDR_ERROR   12'hb01
`define NCS_ADDR_CONTROL 12'hb02
`define NCS_ADDR_TRIGGER 12'hb03
`define NCS_BIT_PENDING  0
`define NCS_BIT_ERROR    0
`define NCS_BIT_WREN     0
`define NCS_BIT_RELOAD   1
`define NCS_BIT_STORE    0
`define NCS_CONTROL_RST  8'h00
`define NCS_WREN_RST     1'b0
`define NCS_XFER_CYCLES  16'h0040
`endif

//--- ncs_xfer.v
// Transfer engine that copies between the buffer bank and the store.
`default_nettype none
module ncs_xfer #(
  parameter XFER_CYCLES = 16'h0040
) (
  input  wire        ref_clk,    // Serial port clock.
  input  wire        nrst,       // Synchronous reset, active low.
  input  wire        start,      // One-cycle start pulse.
  input  wire        is_write,   // 1 store write, 0 reload from store.
  input  wire        data_bad,   // Integrity check result from the array.
  output reg         busy,       // Transfer in progress.
  output reg         done,       // One-cycle end pulse.
  output reg         err         // Last transfer saw bad data.
);
  reg [15:0] count;

  // Count out a fixed transfer time; the result is checked at the end.
  always @(posedge ref_clk) begin
    if (!nrst) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      err   <= 1'b0;
      count <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        count <= XFER_CYCLES;
      end else if (busy) begin
        if (count == 16'h0001) begin
          busy <= 1'b0;
          done <= 1'b1;
          err  <= data_bad;
        end
        count <= count - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

//--- ncs_chk_assertions.sv
// Port assertions for the config store control block.
`default_nettype none
module ncs_chk #(parameter XFER_CYCLES = 16'h0040) (
  input wire logic ref_clk, nrst, reg_wr, reg_rd, status_pin_sel,
  input wire logic status_pin, nvm_write_go, soft_reset,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata, reg_rdata);
  logic wen; // Enable bit as last written.
  // Mirror the enable bit so that a commit can never outrun it.
  always_ff @(posedge ref_clk) if (!nrst) wen <= 1'b0;
    else if (reg_wr && reg_addr == 12'hb02) wen <= reg_wdata[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  pin_off_a: assert property (!status_pin_sel |=> !status_pin)
    else $error("pin set");
  pin_on_a: assert property (
    reg_wr && reg_addr == 12'hb03 && reg_wdata[0] ##1 status_pin_sel
    |=> status_pin) else $error("pin clear");
  go_gate_a: assert property (nvm_write_go |-> wen)
    else $error("commit unarmed");
  go_pulse_a: assert property (nvm_write_go |=> !nvm_write_go)
    else $error("commit held");
  rst_pulse_a: assert property (soft_reset |=> !soft_reset)
    else $error("reload held");
  unmapped_a: assert property (reg_rd && reg_addr[11:2] != 10'h2c0
    |=> reg_rdata == 8'h00) else $error("unmapped data");
endmodule
bind ncs_ctrl ncs_chk #(.XFER_CYCLES(XFER_CYCLES)) ncs_chk_i (.ref_clk,
  .nrst, .reg_wr, .reg_rd, .status_pin_sel, .status_pin, .nvm_write_go,
  .soft_reset, .reg_addr, .reg_wdata, .reg_rdata);
`default_nettype wire

//--- ncs_nvm_model.sv
// Store array stand-in that reports the integrity of a transfer.
`default_nettype none
module ncs_nvm_model (
  input  wire logic ref_clk,     // Port clock.
  input  wire logic bad,         // Bench asks for corrupt data.
  output var  logic nvm_data_bad // Integrity result.
);
  timeunit 1ns; timeprecision 1ns;
  // Registered, since an array read-back lags its request by a cycle.
  initial nvm_data_bad = 1'b0;
  always @(posedge ref_clk) nvm_data_bad <= bad;
endmodule
`default_nettype wire

//--- nvm_config_store_control_test.sv
// Self-checking bench for the config store control block.
`default_nettype none
module nvm_config_store_control_test;
  timeunit 1ns; timeprecision 1ns;
  logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, sel = 0, boot = 1;
  logic bad = 0, status_pin, nvm_data_bad, nvm_write_go, soft_reset;
  logic [11:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata, lf = 8'h2f;
  int          n_errors = 0, checks_done = 0, cyc = 0, n_go = 0, n_sr = 0;
  ncs_ctrl #(.XFER_CYCLES(16'h0004)) ncs_ctrl_i (.ref_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .status_pin_sel(sel),
    .boot_sel_pin(boot), .nvm_data_bad, .status_pin, .nvm_write_go,
    .soft_reset);
  ncs_nvm_model ncs_nvm_model_i (.ref_clk, .bad, .nvm_data_bad);
  initial forever #50 ref_clk = ~ref_clk;
  // Count pulses at every edge; a hang ends the run as a mismatch.
  always @(posedge ref_clk) begin
    n_go += nvm_write_go; n_sr += soft_reset;
    if (++cyc > 900) begin n_errors++; tally_and_finish(); end
  end
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], ^(v & 8'hb8)};
  endfunction
  task automatic chk(input logic [7:0] s, e, input string nm);
    checks_done++;
    if (s !== e) begin n_errors++; $display("BAD %s %h %h", nm, e, s); end
  endtask
  task automatic step(input int n); repeat (n) @(posedge ref_clk); #1;
  endtask
  // One register access; the strobe stands for exactly one edge.
  task automatic acc(input logic w, logic [11:0] a, logic [7:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = w; reg_rd = !w; step(1);
    reg_wr = 0; reg_rd = 0; step(1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    step(6); nrst = 1;
    for (int a = 'hb00; a < 'hb05; a++) begin
      acc(0, 12'(a), 0); chk(reg_rdata, 0, "rst");
    end
    // Protected and armed store writes, random integrity result.
    for (int k = 0; k < 4; k++) begin
      lf = lfsr(lf); bad = lf[0]; sel = k[1]; n_go = 0;
      acc(1, 'hb02, 8'(k & 1)); acc(1, 'hb03, 1); acc(0, 'hb00, 0);
      chk(reg_rdata, 1, "busy");
      chk(8'(status_pin), 8'(sel), "pin");
      step(8); chk(8'(n_go), 8'(k & 1), "go");
      acc(0, 'hb03, 0); chk(reg_rdata, 0, "trig");
      acc(0, 'hb01, 0); chk(reg_rdata, 8'(bad), "err");
    end
    acc(1, 'hb02, 2); step(8); chk(8'(n_sr), 0, "rld off");
    boot = 0; step(3); acc(1, 'hb02, 3); step(8);
    acc(0, 'hb02, 0); chk(reg_rdata, 1, "ctl");
    chk(8'(n_sr), 1, "rld");
    nrst = 0; step(2); nrst = 1;
    acc(0, 'hb02, 0); chk(reg_rdata, 0, "ctl");
    tally_and_finish();
  end
endmodule
`default_nettype wire
